// ===== design/bpfs_chan.v
// One channel's power-up sequence, protection windows and hiccup control.
// Assumes synchronised inputs and a pwm_edge pulse per switching cycle.
`include "bpfs_map.vh"
module bpfs_chan #(
  parameter [15:0] SS_CYC = `BPFS_SS_CYC,
  parameter [15:0] PGD_CYC = `BPFS_PGD_CYC,
  parameter [15:0] HIC_CYC = `BPFS_HIC_CYC
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire chip_off,
  input wire pwm_edge,
  input wire uv_raw,
  input wire [1:0] oc_raw,
  input wire ot_now,
  input wire ot_clear,
  input wire force_hiccup,
  output reg run_r,
  output reg pg_r,
  output reg need_hiccup,
  output reg [3:0] flags_r
);
  // ---------------------------------------------------------
  // State machine
  // ---------------------------------------------------------
  localparam [2:0] S_OFF = 3'd0;
  localparam [2:0] S_SS = 3'd1;
  localparam [2:0] S_PGD = 3'd2;
  localparam [2:0] S_ON = 3'd3;
  localparam [2:0] S_HIC = 3'd4;
  localparam integer UV_DEB_I = `BPFS_UV_DEB_CYC;
  localparam [7:0] UV_DEB = UV_DEB_I[7:0];

  reg [2:0] st_r;
  reg [15:0] tmr_r;
  reg [7:0] uv_cnt_r;
  reg [3:0] oc_cnt_r;
  reg ot_lat_r;
  wire oc_arm = (st_r == S_SS) || (st_r == S_PGD) || (st_r == S_ON);
  wire uv_arm = (st_r == S_ON);
  wire uv_trip = uv_arm && (uv_cnt_r > UV_DEB);
  wire oc_trip = oc_arm && (oc_cnt_r > `BPFS_OC_CYCLES);
  wire ot_trip = oc_arm && ot_now;

  // Trip request goes to the pairing logic in the same cycle
  always @* begin
    need_hiccup = uv_trip || oc_trip || ot_trip;
  end

  // Debounce; count restarts as soon as the condition drops out
  always @(posedge clk) begin
    if (rst || !uv_arm || !uv_raw) begin
      uv_cnt_r <= 8'h00;
    end else if (uv_cnt_r != 8'hff) begin
      uv_cnt_r <= uv_cnt_r + 8'h01;
    end
  end

  // Count switching cycles with every phase limited
  always @(posedge clk) begin
    if (rst || !oc_arm || !(&oc_raw)) begin
      oc_cnt_r <= 4'h0;
    end else if (pwm_edge && oc_cnt_r != 4'hf) begin
      oc_cnt_r <= oc_cnt_r + 4'h1;
    end
  end

  // Sequencer; chip shutdown and disable override all
  always @(posedge clk) begin
    if (rst || chip_off || !enable) begin
      st_r <= S_OFF;
      tmr_r <= 16'h0000;
      ot_lat_r <= 1'b0;
      flags_r <= 4'h0;
    end else begin
      case (st_r)
        S_OFF: begin
          st_r <= S_SS;
          tmr_r <= 16'h0000;
          flags_r <= 4'h0;
        end
        S_SS, S_PGD, S_ON: begin
          if (need_hiccup || force_hiccup) begin
            st_r <= S_HIC;
            tmr_r <= 16'h0000;
            ot_lat_r <= ot_trip;
            flags_r <= flags_r | {1'b0, ot_trip, oc_trip, uv_trip};
          end else if (st_r == S_SS && tmr_r >= SS_CYC) begin
            st_r <= S_PGD;
            tmr_r <= 16'h0000;
          end else if (st_r == S_PGD && tmr_r >= PGD_CYC) begin
            st_r <= S_ON;
            flags_r <= 4'h0;
          end else if (st_r != S_ON) begin
            tmr_r <= tmr_r + 16'h0001;
          end
        end
        S_HIC: begin
          if (tmr_r < HIC_CYC) begin
            tmr_r <= tmr_r + 16'h0001;
          end else if (!ot_lat_r || ot_clear) begin
            st_r <= S_SS;
            tmr_r <= 16'h0000;
            ot_lat_r <= 1'b0;
          end
        end
        default: st_r <= S_OFF;
      endcase
    end
  end

  // Registered run and power-good levels
  always @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b0;
      pg_r <= 1'b0;
    end else begin
      run_r <= oc_arm && !need_hiccup && !force_hiccup && !chip_off &&
               enable;
      pg_r <= uv_arm && !need_hiccup && !force_hiccup && !chip_off &&
              enable;
    end
  end
endmodule

// ===== design/bpfs_map.vh
// Constants for the buck protection and fault sequencer.
// Assumes a 100 MHz core clock; counts other than BPFS_OC_CYCLES and BPFS_SLOTS are in core clock cycles.
`ifndef BPFS_MAP_VH
`define BPFS_MAP_VH
`define BPFS_CLK_MHZ 100
// Under-voltage debounce, 1500 ns, least time rounded up
`define BPFS_UV_DEB_NS 1500
`define BPFS_UV_DEB_CYC ((`BPFS_UV_DEB_NS * `BPFS_CLK_MHZ + 999) / 1000)
// All-phase over-current persistence, in switching cycles
`define BPFS_OC_CYCLES 4'h8
// Fault frame period, 36 us
`define BPFS_FRAME_US 36
`define BPFS_FRAME_CYC (`BPFS_FRAME_US * `BPFS_CLK_MHZ)
// Frame slot count: alert slot plus four flags per channel
`define BPFS_SLOTS 9
// Soft start and power-good delay defaults
`define BPFS_SS_CYC 16'h0800
`define BPFS_PGD_CYC 16'h0400
// Hiccup idle default
`define BPFS_HIC_CYC 16'h1000
`endif

// ===== design/bpfs_top.v
// Protection and fault-reporting sequencer for a two-channel buck.
// Assumes comparator results arrive asynchronously from analog pins.
//
// Behaviour
// - UV below threshold over 1.5 us drops power good, switches off
// - UV trip enters hiccup, then normal power-up after interval
// - UV armed after power-good delay; off in shutdown and hiccup idle
// - OC armed from soft start; off in shutdown and hiccup idle
// - Each phase on-time truncated in any cycle over current limit
// - All phases over limit more than 8 cycles: shut down, hiccup
// - OT configuration per channel latched from soft-start strap
// - Config one: limit pin above OT pin flags OT, shuts down
// - After OT, restart after hiccup only once below reset threshold
// - Config two: external temperature above reference flags OT
// - OT armed from soft start; off in shutdown and hiccup idle
// - Die over temperature shuts chip down, PWM outputs high impedance
// - Die monitor active only with supply valid and an enable high
// - Below recovery point die shutdown clears, normal power-up follows
// - Fault output repeats alert slot then channel flags, fixed period
// - Active fault bits driven high in each frame
// - Frames start on confirmed fault, stop after power good returns
// - Frame in progress completes after power good returns
// - Paired mode: either channel's hiccup puts both into hiccup
`include "bpfs_map.vh"
module bpfs_top #(
  parameter [15:0] HIC_CYC = `BPFS_HIC_CYC,
  parameter [15:0] SS_CYC = `BPFS_SS_CYC,
  parameter [15:0] PGD_CYC = `BPFS_PGD_CYC,
  parameter [11:0] SLOT_CYC = `BPFS_FRAME_CYC / `BPFS_SLOTS
) (
  input wire clk,
  input wire rst,
  input wire [1:0] enable_pin,
  input wire internal_supply_rail,
  input wire paired_mode,
  input wire [1:0] ot_config_strap,
  input wire [1:0] pwm_edge,
  input wire [1:0] undervoltage_trip,
  input wire [3:0] overcurrent_trip,
  input wire [1:0] ot_limit_cmp,
  input wire [1:0] ot_limit_rst_cmp,
  input wire [1:0] ot_ext_cmp,
  input wire [1:0] ot_ext_rst_cmp,
  input wire die_hot,
  input wire die_cool,
  input wire [3:0] pwm_req,
  output reg [3:0] pwm_out_r,
  output reg [3:0] pwm_oe_r,
  output reg [1:0] power_good_out,
  output reg fault_out_r,
  output reg die_thermal_shutdown
);
  // ---------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------
  localparam NS = 22;
  wire [NS-1:0] raw = {enable_pin, internal_supply_rail, paired_mode,
                       ot_config_strap, undervoltage_trip,
                       overcurrent_trip, ot_limit_cmp, ot_limit_rst_cmp,
                       ot_ext_cmp, ot_ext_rst_cmp, die_hot, die_cool};
  reg [NS-1:0] s1_r;
  reg [NS-1:0] s2_r;
  // Two flops per pin; only the second stage feeds logic
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= {NS{1'b0}};
      s2_r <= {NS{1'b0}};
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  wire [1:0] en_s = s2_r[21:20];
  wire rail_s = s2_r[19];
  wire pmode_s = s2_r[18];
  wire [1:0] strap_s = s2_r[17:16];
  wire [1:0] uv_s = s2_r[15:14];
  wire [3:0] oc_s = s2_r[13:10];
  wire [1:0] otl_s = s2_r[9:8];
  wire [1:0] otlr_s = s2_r[7:6];
  wire [1:0] ote_s = s2_r[5:4];
  wire [1:0] oter_s = s2_r[3:2];
  wire hot_s = s2_r[1];
  wire cool_s = s2_r[0];

  // ---------------------------------------------------------
  // Strap capture and die thermal shutdown
  // ---------------------------------------------------------
  reg [1:0] cfg_r;
  reg [1:0] cfg_cnt_r;
  wire cfg_done = (cfg_cnt_r == 2'b11);
  // Strap caught once the synchroniser holds it; channels wait for it
  always @(posedge clk) begin
    if (rst) begin
      cfg_r <= 2'b00;
      cfg_cnt_r <= 2'b00;
    end else if (!cfg_done) begin
      cfg_r <= strap_s;
      cfg_cnt_r <= cfg_cnt_r + 2'b01;
    end
  end

  // Hysteretic die monitor; cleared when not armed
  wire tsd_arm = rail_s && (|en_s);
  always @(posedge clk) begin
    if (rst || !tsd_arm) begin
      die_thermal_shutdown <= 1'b0;
    end else if (hot_s) begin
      die_thermal_shutdown <= 1'b1;
    end else if (cool_s) begin
      die_thermal_shutdown <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // Channels
  // ---------------------------------------------------------
  wire [1:0] run;
  wire [1:0] pg;
  wire [1:0] need;
  wire [7:0] flags;
  wire chip_off = die_thermal_shutdown || !cfg_done;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      // Detection source picked by the latched configuration
      wire ot_now = cfg_r[g] ? ote_s[g] : otl_s[g];
      wire ot_clr = cfg_r[g] ? !oter_s[g] : !otlr_s[g];
      bpfs_chan #(
        .SS_CYC(SS_CYC),
        .PGD_CYC(PGD_CYC),
        .HIC_CYC(HIC_CYC)
      ) u_chan (
        .clk(clk),
        .rst(rst),
        .enable(en_s[g]),
        .chip_off(chip_off),
        .pwm_edge(pwm_edge[g]),
        .uv_raw(uv_s[g]),
        .oc_raw(oc_s[2*g+1:2*g]),
        .ot_now(ot_now),
        .ot_clear(ot_clr),
        .force_hiccup(pmode_s && need[1-g]),
        .run_r(run[g]),
        .pg_r(pg[g]),
        .need_hiccup(need[g]),
        .flags_r(flags[4*g+3:4*g])
      );
    end
  endgenerate

  // ---------------------------------------------------------
  // PWM gating
  // ---------------------------------------------------------
  // Per phase cut latch: once over limit, the phase stays low until its
  // next switching cycle, so the on-time is truncated and not chopped
  wire [3:0] cut;
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : ph
      reg cut_r;
      // A limit hit in the same cycle as the new period wins
      always @(posedge clk) begin
        if (rst) begin
          cut_r <= 1'b0;
        end else if (oc_s[p]) begin
          cut_r <= 1'b1;
        end else if (pwm_edge[p/2]) begin
          cut_r <= 1'b0;
        end
      end
      assign cut[p] = cut_r | oc_s[p];
    end
  endgenerate

  // Per phase truncation: a limited phase is held low for the cycle
  always @(posedge clk) begin
    if (rst) begin
      pwm_out_r <= 4'h0;
      pwm_oe_r <= 4'h0;
      power_good_out <= 2'b00;
    end else begin
      pwm_out_r <= pwm_req & ~cut &
                   {{2{run[1]}}, {2{run[0]}}};
      pwm_oe_r <= {4{!die_thermal_shutdown}};
      power_good_out <= pg;
    end
  end

  // ---------------------------------------------------------
  // Fault frame serialiser
  // ---------------------------------------------------------
  localparam integer LAST_SLOT_I = `BPFS_SLOTS - 1;
  localparam [3:0] LAST_SLOT = LAST_SLOT_I[3:0];
  reg active_r;
  reg [3:0] slot_r;
  reg [11:0] scnt_r;
  reg [7:0] snap_r;
  // Die shutdown shows in both channels' over-temperature slots
  wire [7:0] die_bits = {1'b0, die_thermal_shutdown, 2'b00,
                         1'b0, die_thermal_shutdown, 2'b00};
  wire any_fault = |flags | die_thermal_shutdown;
  wire frame_end = (slot_r == LAST_SLOT) && (scnt_r == SLOT_CYC - 12'd1);
  wire pg_back = &(pg | ~en_s) && !(|flags);
  wire [8:0] word = {snap_r, 1'b1};

  // Frames run while any fault holds; end only at a frame boundary
  always @(posedge clk) begin
    if (rst) begin
      active_r <= 1'b0;
      slot_r <= 4'h0;
      scnt_r <= 12'h000;
      snap_r <= 8'h00;
      fault_out_r <= 1'b0;
    end else begin
      if (!active_r) begin
        fault_out_r <= 1'b0;
        if (any_fault) begin
          active_r <= 1'b1;
          slot_r <= 4'h0;
          scnt_r <= 12'h000;
          snap_r <= flags | die_bits;
        end
      end else begin
        fault_out_r <= word[slot_r];
        if (scnt_r == SLOT_CYC - 12'd1) begin
          scnt_r <= 12'h000;
          if (frame_end) begin
            slot_r <= 4'h0;
            snap_r <= flags | die_bits;
            if (pg_back && !any_fault) begin
              active_r <= 1'b0;
            end
          end else begin
            slot_r <= slot_r + 4'h1;
          end
        end else begin
          scnt_r <= scnt_r + 12'h001;
        end
      end
    end
  end
endmodule

// ===== sim/bpfs_props.sv
// Port checker for the fault sequencer, bound into bpfs_top.
// Assumes one clock; frame tracking is derived from SLOT_CYC.
module bpfs_props #(parameter [11:0] SLOT_CYC = 12'h190) (
  input wire clk,
  input wire rst,
  input wire internal_supply_rail,
  input wire [3:0] pwm_out_r,
  input wire [3:0] pwm_oe_r,
  input wire [1:0] power_good_out,
  input wire fault_out_r,
  input wire die_thermal_shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------
  // Frame tracker
  // ----------------
  localparam int FR = 9 * SLOT_CYC;
  logic act_r;
  logic dh_r;
  int cnt_r;
  // Frame can only stop at a boundary, so low at count 0 ends it
  always @(posedge clk) begin
    if (rst) begin
      act_r <= 1'b0;
      cnt_r <= 0;
      dh_r <= 1'b0;
    end else if (!act_r) begin
      act_r <= fault_out_r;
      cnt_r <= 1;
      dh_r <= die_thermal_shutdown && $past(die_thermal_shutdown, 2);
    end else begin
      cnt_r <= (cnt_r == FR - 1) ? 0 : cnt_r + 1;
      dh_r <= (cnt_r == 0) ? die_thermal_shutdown
        && $past(die_thermal_shutdown, 2) : dh_r && die_thermal_shutdown;
      if (cnt_r == 0 && !fault_out_r)
        act_r <= 1'b0;
    end
  end
  // ----------------
  // Properties
  // ----------------
  sequence s_dts_on;
    die_thermal_shutdown [*4];
  endsequence
  sequence s_rail_off;
    !internal_supply_rail [*6];
  endsequence
  property p_alert;
    act_r && cnt_r > 0 && cnt_r < SLOT_CYC |-> fault_out_r;
  endproperty
  a_alert: assert property (p_alert) else $error("alert slot low");
  property p_spare;
    act_r && (cnt_r / SLOT_CYC == 4 || cnt_r / SLOT_CYC == 8)
      |-> !fault_out_r;
  endproperty
  a_spare: assert property (p_spare) else $error("spare slot high");
  property p_stop;
    act_r && cnt_r == 0 && !fault_out_r |-> power_good_out != 2'b00;
  endproperty
  a_stop: assert property (p_stop) else $error("frames stopped early");
  property p_flag_die;
    act_r && dh_r && (cnt_r == 3 * SLOT_CYC + 2 || cnt_r == 7 * SLOT_CYC + 2)
      |-> fault_out_r;
  endproperty
  a_flag_die: assert property (p_flag_die) else $error("die flag low");
  property p_pwm_off0;
    $fell(power_good_out[0]) |-> ##[0:3] pwm_out_r[1:0] == 2'b00;
  endproperty
  a_pwm_off0: assert property (p_pwm_off0) else $error("ch0 still on");
  property p_pwm_off1;
    $fell(power_good_out[1]) |-> ##[0:3] pwm_out_r[3:2] == 2'b00;
  endproperty
  a_pwm_off1: assert property (p_pwm_off1) else $error("ch1 still on");
  property p_die_oe;
    s_dts_on |-> pwm_oe_r == 4'h0 && power_good_out == 2'b00;
  endproperty
  a_die_oe: assert property (p_die_oe) else $error("pwm not released");
  property p_die_gate;
    s_rail_off |=> !$rose(die_thermal_shutdown);
  endproperty
  a_die_gate: assert property (p_die_gate) else $error("die trip no rail");
endmodule
bind bpfs_top bpfs_props #(.SLOT_CYC(SLOT_CYC)) u_props (.clk(clk),
  .rst(rst), .internal_supply_rail(internal_supply_rail),
  .pwm_out_r(pwm_out_r), .pwm_oe_r(pwm_oe_r),
  .power_good_out(power_good_out), .fault_out_r(fault_out_r),
  .die_thermal_shutdown(die_thermal_shutdown));

// ===== sim/bpfs_stage.sv
// Power stage stand-in: switching pulses and raw PWM per phase.
// Assumes the bench clock; both channels share a 20-cycle period.
module bpfs_stage (
  input wire clk,
  output logic [1:0] pwm_edge,
  output logic [3:0] pwm_req
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  // Phase moves on the falling edge, away from the sampling edge
  always @(negedge clk) begin
    ph <= (ph == 19) ? 0 : ph + 1;
  end
  // Edge pulse opens each cycle; request high for its first half
  assign pwm_edge = {2{ph == 0}};
  assign pwm_req = {4{ph < 10}};
endmodule

// ===== sim/bpfs_top_tb.sv
// Self-checking bench for the protection and fault sequencer.
// Assumes short sim counts: hiccup 32, soft start 16, slot 10.
module bpfs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOT = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rail, pmode, hot, cool;
  logic [1:0] en, strap, uv, olc, olr, oec, oer;
  logic [3:0] oc;
  wire [3:0] pout, poe, preq;
  wire [1:0] pg, pedge;
  wire fout, dts;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  // ----------------
  // Harness
  // ----------------
  always #5 clk = ~clk;
  bpfs_stage u_stage (.clk(clk), .pwm_edge(pedge), .pwm_req(preq));
  bpfs_top #(.HIC_CYC(16'h0020), .SS_CYC(16'h0010), .PGD_CYC(16'h0008),
    .SLOT_CYC(12'h00a)) dut (.clk(clk), .rst(rst), .enable_pin(en),
    .internal_supply_rail(rail), .paired_mode(pmode),
    .ot_config_strap(strap), .pwm_edge(pedge), .undervoltage_trip(uv),
    .overcurrent_trip(oc), .ot_limit_cmp(olc), .ot_limit_rst_cmp(olr),
    .ot_ext_cmp(oec), .ot_ext_rst_cmp(oer), .die_hot(hot),
    .die_cool(cool), .pwm_req(preq), .pwm_out_r(pout), .pwm_oe_r(poe),
    .power_good_out(pg), .fault_out_r(fout), .die_thermal_shutdown(dts));
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the expected few thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  // ----------------
  // Scenarios
  // ----------------
  task automatic wait_pg(logic [1:0] want, int lim);
    for (int i = 0; i < lim && pg !== want; i++) @(negedge clk);
    chk("power good", pg, want);
  endtask
  // Sag held from power-up is not armed before the delay ends
  task automatic t_start;
    {rail, en, uv[0]} = 4'hf;
    wait_pg(2'b11, 300);
    repeat (100) @(negedge clk);
    uv[0] = 1'b0;
    repeat (3) @(negedge clk);
    uv[0] = 1'b1;
    repeat (100) @(negedge clk);
    uv[0] = 1'b0;
    chk("uv restart", pg, 2'b11);
    repeat (5) @(negedge clk);
  endtask
  task automatic t_uv;
    uv[0] = 1'b1;
    repeat (145) @(negedge clk);
    chk("uv early", pg, 2'b11);
    wait_pg(2'b10, 30);
    chk("uv off", pout[1:0], 2'b00);
    for (int i = 0; i < 20 && fout !== 1'b1; i++) @(negedge clk);
    chk("frame on", fout, 1'b1);
    repeat (SLOT + 5) @(negedge clk);
    chk("uv flag", fout, 1'b1);
    repeat (SLOT) @(negedge clk);
    chk("oc flag", fout, 1'b0);
    uv[0] = 1'b0;
    wait_pg(2'b11, 400);
    repeat (18 * SLOT) @(negedge clk);
    repeat (90) begin
      @(negedge clk);
      chk("frame off", fout, 1'b0);
    end
  endtask
  // One phase cut per cycle, then both phases long enough to hiccup
  task automatic t_oc;
    oc = 4'b0100;
    @(posedge pedge[1]);
    repeat (5) @(negedge clk);
    chk("cut phase", pout[3:2], 2'b10);
    oc = 4'b1100;
    repeat (150) @(negedge clk);
    chk("oc count", pg, 2'b11);
    wait_pg(2'b01, 100);
    oc = 4'b0000;
    wait_pg(2'b11, 400);
  endtask
  // Strap 2'b10: channel 0 limit-pin compare, channel 1 external
  task automatic t_ot(int c);
    if (c == 0)
      oec[0] = 1'b1;
    else
      olc[1] = 1'b1;
    repeat (50) @(negedge clk);
    chk("other config", pg, 2'b11);
    {olc[c], olr[c], oec[c], oer[c]} = 4'hf;
    wait_pg(c ? 2'b01 : 2'b10, 20);
    {olc[c], oec[c]} = 2'b00;
    repeat (200) @(negedge clk);
    chk("ot held", pg[c], 1'b0);
    {olr[c], oer[c]} = 2'b00;
    wait_pg(2'b11, 400);
  endtask
  task automatic t_die;
    {rail, hot} = 2'b01;
    repeat (20) @(negedge clk);
    chk("rail gate", dts, 1'b0);
    rail = 1'b1;
    for (int i = 0; i < 10 && dts !== 1'b1; i++) @(negedge clk);
    chk("die trip", dts, 1'b1);
    repeat (150) @(negedge clk);
    chk("hi z", poe, 4'h0);
    hot = 1'b0;
    repeat (20) @(negedge clk);
    chk("hysteresis", dts, 1'b1);
    cool = 1'b1;
    for (int i = 0; i < 10 && dts !== 1'b0; i++) @(negedge clk);
    chk("die clear", dts, 1'b0);
    cool = 1'b0;
    wait_pg(2'b11, 400);
  endtask
  // Mid-run reset into paired mode; one sag idles both channels
  task automatic t_paired;
    {pmode, rst} = 2'b11;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    wait_pg(2'b11, 300);
    uv[1] = 1'b1;
    wait_pg(2'b00, 200);
    uv[1] = 1'b0;
    wait_pg(2'b11, 400);
  endtask
  // Main sequence: everything defined at time zero, reset two cycles
  initial begin
    {rail, pmode, hot, cool, en, uv, olc, olr, oec, oer, oc} = 0;
    strap = 2'b10;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_start;
    t_uv;
    t_oc;
    t_ot(0);
    t_ot(1);
    t_die;
    t_paired;
    give_verdict;
  end
endmodule
